/* core/jtag_tap_boundary_scan.v */
// Contract
// - Sample mode-select and data-in on clock rise
// - Data-out changes only on clock fall
// - Logic runs from mclk; test clock sampled as an async input
// - Shift least significant bit first
// - Data-out high impedance outside shift states
// - Five-bit instruction selects data path
// - One clock pulse enables test pins
// - Five mode-select highs reach reset state
// - One low from reset goes idle
// - Reset pin low releases test pins
// - Status bits shift out during instruction
// - Update-IR latches the shifted instruction
// - Capture loads inputs, shift outputs them
// - Latched outputs change only at Update-DR
// - Update-IR may go straight to scan
// - Identification instruction active after reset
// - External test drives latches immediately; preload
// - Service bus instruction keeps clocks in sleep
// - Code 0x01 selects 32-bit identification
// - 0x02 sample/preload, 0x03 external test
`timescale 1ns/10ps
`default_nettype none
`include "jtag_tap_regs.vh"

module jtag_tap_boundary_scan #(
    parameter BSR_LEN = 8,
    parameter [31:0] ID_WORD = 32'h1234_5679 // Arbitrary identity value
) (
    input wire mclk,
    input wire resetn,
    input wire tckPin,
    input wire tmsPin,
    input wire tdiPin,
    input wire extResetn,
    output reg tdoOut_ff,
    output reg tdoOen_n_ff,
    output reg pinsTestMode_ff,
    input wire [BSR_LEN-1:0] pinInputs,
    input wire [BSR_LEN-1:0] coreOutputs,
    output reg [BSR_LEN-1:0] pinOutputs_ff,
    output reg [`IR_WIDTH-1:0] activeInsn_ff,
    output reg keepClocks_ff,
    input wire sleepReq,
    input wire [2:0] statusBits
);

localparam TLR = 4'h0;
localparam CDR = 4'h3;
localparam SDR = 4'h4;
localparam UDR = 4'h8;
localparam CIR = 4'ha;
localparam SIR = 4'hb;
localparam UIR = 4'hf;
localparam [`IR_WIDTH-1:0] SAB_BASE = 5'h10;

// Data path selector codes
localparam [1:0] PATH_BYPASS = 2'h0;
localparam [1:0] PATH_IDENT = 2'h1;
localparam [1:0] PATH_BSR = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: the test clock is just another async input
reg [1:0] tckSync_ff;
reg [1:0] tmsSync_ff;
reg [1:0] tdiSync_ff;
reg [1:0] rstSync_ff;
reg tckPrev_ff;
wire tckRise;
wire tckFall;

// Test clock: only the second stage and its delayed copy are read
always @(posedge mclk) begin
    if (!resetn) begin
        tckSync_ff <= 2'b00;
        tckPrev_ff <= 1'b0;
    end else begin
        tckSync_ff <= {tckSync_ff[0], tckPin};
        tckPrev_ff <= tckSync_ff[1];
    end
end

assign tckRise = tckSync_ff[1] & ~tckPrev_ff;
assign tckFall = ~tckSync_ff[1] & tckPrev_ff;

// Idle high, as the lines float high with no controller attached
always @(posedge mclk) begin
    if (!resetn) begin
        tmsSync_ff <= 2'b11;
    end else begin
        tmsSync_ff <= {tmsSync_ff[0], tmsPin};
    end
end

always @(posedge mclk) begin
    if (!resetn) begin
        tdiSync_ff <= 2'b11;
    end else begin
        tdiSync_ff <= {tdiSync_ff[0], tdiPin};
    end
end

// Starts asserted so the pins stay released until the pin is seen high
always @(posedge mclk) begin
    if (!resetn) begin
        rstSync_ff <= 2'b00;
    end else begin
        rstSync_ff <= {rstSync_ff[0], extResetn};
    end
end

// Same depth as the clock, so tms and tdi are taken at the detected rise
wire tmsIn = tmsSync_ff[1];
wire tdiIn = tdiSync_ff[1];
wire extRstLow = ~rstSync_ff[1];

////////////////////////////////////////////////////////////////////////////////
// Controller
wire [3:0] tapState;

tap_fsm uFsm (
    .mclk(mclk),
    .resetn(resetn),
    .tckRise(tckRise),
    .tmsIn(tmsIn),
    .state_ff(tapState)
);

////////////////////////////////////////////////////////////////////////////////
// Pin ownership: first clock pulse claims, reset pin low releases
reg nxt_pinsTestMode;

// Release wins over a claim in the same cycle
always @* begin
    if (extRstLow) begin
        nxt_pinsTestMode = 1'b0;
    end else if (tckRise) begin
        nxt_pinsTestMode = 1'b1;
    end else begin
        nxt_pinsTestMode = pinsTestMode_ff;
    end
end

always @(posedge mclk) begin
    if (!resetn) begin
        pinsTestMode_ff <= 1'b0;
    end else begin
        pinsTestMode_ff <= nxt_pinsTestMode;
    end
end

////////////////////////////////////////////////////////////////////////////////
// State decode
wire inTestReset = (tapState == TLR);
wire inCaptureIr = (tapState == CIR);
wire inShiftIr = (tapState == SIR);
wire inUpdateIr = (tapState == UIR);
wire inCaptureDr = (tapState == CDR);
wire inShiftDr = (tapState == SDR);
wire inUpdateDr = (tapState == UDR);
wire shiftActive = inShiftIr | inShiftDr;

////////////////////////////////////////////////////////////////////////////////
// Instruction path
reg [`IR_WIDTH-1:0] irShift_ff;

// Shift stage: capture status, then one tdi bit per rise
always @(posedge mclk) begin
    if (!resetn) begin
        irShift_ff <= `INSN_IDENT;
    end else if (tckRise && inCaptureIr) begin
        irShift_ff <= {statusBits, `IR_CAPTURE_LSB};
    end else if (tckRise && inShiftIr) begin
        irShift_ff <= {tdiIn, irShift_ff[`IR_WIDTH-1:1]};
    end
end

// Parallel stage: a scan alone never changes the active instruction
always @(posedge mclk) begin
    if (!resetn) begin
        activeInsn_ff <= `INSN_IDENT;
    end else if (tckRise && inTestReset) begin
        activeInsn_ff <= `INSN_IDENT;
    end else if (tckRise && inUpdateIr) begin
        activeInsn_ff <= irShift_ff;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Data registers
wire selId = (activeInsn_ff == `INSN_IDENT);
wire selBsr = (activeInsn_ff == `INSN_SAMPLE_PRELOAD) ||
    (activeInsn_ff == `INSN_EXTEST);
wire extestOn = (activeInsn_ff == `INSN_EXTEST);
reg [1:0] pathSel;

// Anything not decoded falls through to the one-bit path
always @* begin
    if (selId) begin
        pathSel = PATH_IDENT;
    end else if (selBsr) begin
        pathSel = PATH_BSR;
    end else begin
        pathSel = PATH_BYPASS;
    end
end

reg [`ID_WIDTH-1:0] idShift_ff;
reg [BSR_LEN-1:0] bsrShift_ff;
reg [BSR_LEN-1:0] bsrLatch_ff;
reg bypass_ff;

always @(posedge mclk) begin
    if (!resetn) begin
        idShift_ff <= {`ID_WIDTH{1'b0}};
    end else if (tckRise && inCaptureDr) begin
        idShift_ff <= ID_WORD;
    end else if (tckRise && inShiftDr && pathSel == PATH_IDENT) begin
        idShift_ff <= {tdiIn, idShift_ff[`ID_WIDTH-1:1]};
    end
end

// Pin levels are captured whichever boundary instruction is active
always @(posedge mclk) begin
    if (!resetn) begin
        bsrShift_ff <= {BSR_LEN{1'b0}};
    end else if (tckRise && inCaptureDr) begin
        bsrShift_ff <= pinInputs;
    end else if (tckRise && inShiftDr && pathSel == PATH_BSR) begin
        bsrShift_ff <= {tdiIn, bsrShift_ff[BSR_LEN-1:1]};
    end
end

// Output latch: shifting alone never disturbs the pins
always @(posedge mclk) begin
    if (!resetn) begin
        bsrLatch_ff <= {BSR_LEN{1'b0}};
    end else if (tckRise && inUpdateDr && pathSel == PATH_BSR) begin
        bsrLatch_ff <= bsrShift_ff;
    end
end

always @(posedge mclk) begin
    if (!resetn) begin
        bypass_ff <= 1'b0;
    end else if (tckRise && inCaptureDr) begin
        bypass_ff <= 1'b0;
    end else if (tckRise && inShiftDr && pathSel == PATH_BYPASS) begin
        bypass_ff <= tdiIn;
    end
end

// External test takes the pins the moment it is active
reg [BSR_LEN-1:0] nxt_pinOutputs;

always @* begin
    if (extestOn) begin
        nxt_pinOutputs = bsrLatch_ff;
    end else begin
        nxt_pinOutputs = coreOutputs;
    end
end

always @(posedge mclk) begin
    if (!resetn) begin
        pinOutputs_ff <= {BSR_LEN{1'b0}};
    end else begin
        pinOutputs_ff <= nxt_pinOutputs;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Serial output, updated on the fall so the far end samples a stable bit
reg tdoBit;
reg nxt_tdoOen_n;

always @* begin
    if (inShiftIr) begin
        tdoBit = irShift_ff[0];
    end else begin
        case (pathSel)
            PATH_IDENT: tdoBit = idShift_ff[0];
            PATH_BSR: tdoBit = bsrShift_ff[0];
            default: tdoBit = bypass_ff;
        endcase
    end
end

// Driver stays off while the pins belong to normal I/O
always @* begin
    nxt_tdoOen_n = ~(pinsTestMode_ff & shiftActive);
end

always @(posedge mclk) begin
    if (!resetn) begin
        tdoOut_ff <= 1'b0;
    end else if (tckFall) begin
        tdoOut_ff <= tdoBit;
    end
end

always @(posedge mclk) begin
    if (!resetn) begin
        tdoOen_n_ff <= 1'b1;
    end else if (tckFall) begin
        tdoOen_n_ff <= nxt_tdoOen_n;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sleep clock hold: latched at sleep entry from the active instruction
reg sleepPrev_ff;
wire sleepEntry = sleepReq & ~sleepPrev_ff;

always @(posedge mclk) begin
    if (!resetn) begin
        sleepPrev_ff <= 1'b0;
    end else begin
        sleepPrev_ff <= sleepReq;
    end
end

// Decided once at entry; a load made during sleep does not wake the clocks
always @(posedge mclk) begin
    if (!resetn) begin
        keepClocks_ff <= 1'b0;
    end else if (!sleepReq) begin
        keepClocks_ff <= 1'b0;
    end else if (sleepEntry) begin
        keepClocks_ff <= (activeInsn_ff >= SAB_BASE);
    end
end

endmodule // jtag_tap_boundary_scan

`default_nettype wire

/* core/jtag_tap_regs.vh */
`ifndef JTAG_TAP_REGS_VH
`define JTAG_TAP_REGS_VH

// Instruction width and codes
`define IR_WIDTH 5
`define INSN_IDENT 5'h01
`define INSN_SAMPLE_PRELOAD 5'h02
`define INSN_EXTEST 5'h03
`define INSN_BYPASS 5'h1f
// Capture value of the instruction path: status bits, low two fixed 01
`define IR_CAPTURE_LSB 2'b01
// Identification word width
`define ID_WIDTH 32
// Reset-pin filter length in mclk cycles
`define RST_SYNC_STAGES 2

`endif

/* core/tap_fsm.v */
`timescale 1ns/10ps
`default_nettype none

// Sixteen-state test access controller, advanced once per test-clock rise
module tap_fsm (
    input wire mclk,
    input wire resetn,
    input wire tckRise,
    input wire tmsIn,
    output reg [3:0] state_ff
);

localparam TLR = 4'h0, RTI = 4'h1, SDS = 4'h2, CDR = 4'h3, SDR = 4'h4, E1D = 4'h5,
    PDR = 4'h6, E2D = 4'h7, UDR = 4'h8, SIS = 4'h9, CIR = 4'ha, SIR = 4'hb,
    E1I = 4'hc, PIR = 4'hd, E2I = 4'he, UIR = 4'hf;

reg [3:0] nxt_state;

always @* begin
    case (state_ff)
        TLR: nxt_state = tmsIn ? TLR : RTI;
        RTI: nxt_state = tmsIn ? SDS : RTI;
        SDS: nxt_state = tmsIn ? SIS : CDR;
        CDR: nxt_state = tmsIn ? E1D : SDR;
        SDR: nxt_state = tmsIn ? E1D : SDR;
        E1D: nxt_state = tmsIn ? UDR : PDR;
        PDR: nxt_state = tmsIn ? E2D : PDR;
        E2D: nxt_state = tmsIn ? UDR : SDR;
        UDR: nxt_state = tmsIn ? SDS : RTI;
        SIS: nxt_state = tmsIn ? TLR : CIR;
        CIR: nxt_state = tmsIn ? E1I : SIR;
        SIR: nxt_state = tmsIn ? E1I : SIR;
        E1I: nxt_state = tmsIn ? UIR : PIR;
        PIR: nxt_state = tmsIn ? E2I : PIR;
        E2I: nxt_state = tmsIn ? UIR : SIR;
        UIR: nxt_state = tmsIn ? SDS : RTI;
        default: nxt_state = TLR;
    endcase
end

always @(posedge mclk) begin
    if (!resetn) begin
        state_ff <= TLR;
    end else if (tckRise) begin
        state_ff <= nxt_state;
    end
end

endmodule // tap_fsm

`default_nettype wire

/* verification/jtag_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Test controller; tck stands low between calls
module jtag_ctl_model (
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 0;
        tms = 1;
        tdi = 0;
    end
    task automatic clk(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #40 q = tdo;
        tck = 1;
        #40 tck = 0;
    endtask
    task automatic tlr();
        logic q;
        repeat (5) clk(1, 0, q);
        clk(0, 0, q);
    endtask
    task automatic scan(input logic ir, input logic [31:0] d, input int n,
                        output logic [31:0] o);
        logic q;
        o = '0;
        clk(1, 0, q);
        if (ir)
            clk(1, 0, q);
        clk(0, 0, q);
        clk(0, 0, q);
        for (int i = 0; i < n; i++) begin
            clk(i == n - 1, d[i], q);
            o[i] = q;
        end
        clk(1, 0, q);
        clk(0, 0, q);
    endtask
endmodule // jtag_ctl_model
`default_nettype wire

/* verification/jtag_tap_boundary_scan_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module jtag_tap_boundary_scan_tb;
    localparam logic [31:0] ID = 32'h1234_5679; // Arbitrary identity value
    typedef struct {logic [4:0] insn; int n; logic [31:0] din, dout; logic [7:0] pIr, pDr;} row_t;
    logic mclk, resetn, tck, tms, tdi, extResetn, tdoOut, tdoOenN, testMode, keep, sleepReq;
    logic [7:0] pinIn, core, pinOut;
    logic [4:0] insn;
    logic [2:0] status;
    logic [31:0] q;
    wire logic tdoWire;
    int failures = 0;
    int cmpCount = 0;
    row_t rows [5] = '{'{5'h01, 32, 32'h0, ID, 8'hc3, 8'hc3},
        '{5'h1f, 2, 32'h1, 32'h2, 8'hc3, 8'hc3}, '{5'h05, 2, 32'h1, 32'h2, 8'hc3, 8'hc3},
        '{5'h02, 8, 32'h5a, 32'h3c, 8'hc3, 8'hc3}, '{5'h03, 8, 32'h96, 32'h3c, 8'h5a, 8'h96}};
    // Released line floats to its pull-up
    assign tdoWire = tdoOenN ? 1'b1 : tdoOut;
    jtag_tap_boundary_scan #(.BSR_LEN(8), .ID_WORD(ID)) uut (.mclk(mclk), .resetn(resetn),
        .tckPin(tck), .tmsPin(tms), .tdiPin(tdi), .extResetn(extResetn), .tdoOut_ff(tdoOut),
        .tdoOen_n_ff(tdoOenN), .pinsTestMode_ff(testMode), .pinInputs(pinIn),
        .coreOutputs(core), .pinOutputs_ff(pinOut), .activeInsn_ff(insn),
        .keepClocks_ff(keep), .sleepReq(sleepReq), .statusBits(status));
    jtag_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoWire));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    initial begin
        resetn = 0;
        extResetn = 1;
        sleepReq = 0;
        status = 3'h5;
        pinIn = 8'h3c;
        core = 8'hc3;
        repeat (16) @(negedge mclk);
        resetn = 1;
        repeat (4) @(negedge mclk);
        ctl.tlr();
        `CHK(testMode, 1'b1)
        foreach (rows[i]) begin
            ctl.scan(1, rows[i].insn, 5, q);
            `CHK(q[4:0], {status, 2'b01})
            `CHK(pinOut, rows[i].pIr)
            `CHK(insn, rows[i].insn)
            ctl.scan(0, rows[i].din, rows[i].n, q);
            `CHK(q, rows[i].dout)
            `CHK(pinOut, rows[i].pDr)
            `CHK(tdoOenN, 1'b1)
        end
        @(negedge mclk) sleepReq = 1;
        repeat (8) @(negedge mclk);
        `CHK(keep, 1'b0)
        sleepReq = 0;
        ctl.scan(1, 32'h10, 5, q);
        @(negedge mclk) sleepReq = 1;
        repeat (8) @(negedge mclk);
        `CHK(keep, 1'b1)
        sleepReq = 0;
        ctl.tlr();
        ctl.scan(0, 32'h0, 32, q);
        `CHK(q, ID)
        extResetn = 0;
        repeat (8) @(negedge mclk);
        `CHK(testMode, 1'b0)
        extResetn = 1;
        repeat (8) @(negedge mclk);
        ctl.tlr();
        `CHK(testMode, 1'b1)
        print_verdict();
    end
endmodule // jtag_tap_boundary_scan_tb
bind jtag_tap_boundary_scan jtag_tap_properties #(.BSR_LEN(BSR_LEN)) chk (.mclk(mclk),
    .resetn(resetn), .tckPin(tckPin), .extResetn(extResetn), .tdoOut_ff(tdoOut_ff),
    .tdoOen_n_ff(tdoOen_n_ff), .pinsTestMode_ff(pinsTestMode_ff), .coreOutputs(coreOutputs),
    .pinOutputs_ff(pinOutputs_ff), .activeInsn_ff(activeInsn_ff),
    .keepClocks_ff(keepClocks_ff), .sleepReq(sleepReq));
`default_nettype wire

/* verification/jtag_tap_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "jtag_tap_regs.vh"
module jtag_tap_properties #(parameter BSR_LEN = 8) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic tckPin,
    input wire logic extResetn,
    input wire logic tdoOut_ff,
    input wire logic tdoOen_n_ff,
    input wire logic pinsTestMode_ff,
    input wire logic [BSR_LEN-1:0] coreOutputs,
    input wire logic [BSR_LEN-1:0] pinOutputs_ff,
    input wire logic [`IR_WIDTH-1:0] activeInsn_ff,
    input wire logic keepClocks_ff,
    input wire logic sleepReq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Tck half period dwarfs the sync delay, so its level names the launching edge
    a_tdo_on_fall: assert property ($changed(tdoOut_ff) |-> !tckPin)
        else $error("tdo moved, tck high");
    a_oen_on_fall: assert property ($changed(tdoOen_n_ff) |-> !tckPin)
        else $error("oen moved, tck high");
    a_insn_on_rise: assert property ($changed(activeInsn_ff) |-> tckPin)
        else $error("insn moved, tck low");
    a_claim_on_rise: assert property ($rose(pinsTestMode_ff) |-> tckPin && extResetn)
        else $error("bad pin claim");
    a_release_pins: assert property (!extResetn [*6] |-> !pinsTestMode_ff)
        else $error("pins kept");
    a_insn_after_reset: assert property ($rose(resetn) |-> activeInsn_ff == `INSN_IDENT)
        else $error("bad reset insn");
    a_pins_follow_core: assert property (
        $past(resetn) && activeInsn_ff != `INSN_EXTEST && $past(activeInsn_ff) != `INSN_EXTEST
        |-> pinOutputs_ff == $past(coreOutputs)) else $error("pins not core");
    a_keep_needs_sleep: assert property (keepClocks_ff |-> $past(sleepReq))
        else $error("clocks kept awake");
    c_extest: cover property (activeInsn_ff == `INSN_EXTEST);
    c_shift: cover property (!tdoOen_n_ff);
    c_keep: cover property (keepClocks_ff);
endmodule // jtag_tap_properties
`default_nettype wire
